// File: tb/aq_force_assertions.sv
/*
 * Port checker for the action qualifier with software forces.
 * Assumes the bench keeps wb_sel_in at all lanes and does event checks before any continuous force.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aq_force_defs.vh"
module aq_force_checker (
	input wire logic        clk_in, nrst_in, wb_cyc_in, wb_stb_in, wb_we_in,
	input wire logic [7:0]  wb_adr_in,
	input wire logic [3:0]  wb_sel_in,
	input wire logic [31:0] wb_dat_in, wb_dat_out,
	input wire logic        wb_ack_out, wb_err_out, tb_tick_in, up_down_mode_in,
	input wire logic        count_direction_in, ctr_zero_in, ctr_period_in,
	input wire logic        ctr_cmp_a_in, ctr_cmp_b_in,
	input wire logic [1:0]  out_a_event_in,
	input wire logic        pwm_output_a_out, pwm_output_b_out
);
	logic [15:0] act_q;
	logic [1:0]  osa_q, osb_q;
	logic        os_a_q, os_b_q, cf_q;
	wire logic take = wb_cyc_in & wb_stb_in & wb_we_in & !wb_ack_out & !wb_err_out;
	wire logic okb = !cf_q & !os_b_q;
	function automatic logic nx(input logic [1:0] c, input logic l);
		return (c == `ACT_LOW) ? 1'b0 : (c == `ACT_HIGH) ? 1'b1 : (c == `ACT_TOGGLE) ? !l : l;
	endfunction
	// Shadow of the written fields; a pending trigger set on a tick edge wins
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			{act_q, osa_q, osb_q, os_a_q, os_b_q, cf_q} <= '0;
		end else begin
			if (tb_tick_in) {os_a_q, os_b_q} <= 2'h0;
			if (take && wb_adr_in == `OFS_OUT_B_ACTION) act_q <= wb_dat_in[15:0] & `OUT_B_ACTION_MASK;
			if (take && wb_adr_in == `OFS_ONE_SHOT) begin
				{osb_q, osa_q} <= {wb_dat_in[4:3], wb_dat_in[1:0]};
				if (wb_dat_in[2]) os_a_q <= 1'b1;
				if (wb_dat_in[5]) os_b_q <= 1'b1;
			end
			// Event relations are dropped once any continuous force was asked for
			if (take && wb_adr_in == `OFS_CONT_FORCE && wb_dat_in[3:0] != 4'h0) cf_q <= 1'b1;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	a_bus_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out
		|=> wb_ack_out != wb_err_out) else $error("bus answer missing");
	a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
	a_err_unmapped: assert property (take && wb_adr_in > `OFS_STATUS |=> wb_err_out)
		else $error("no error on unmapped");
	a_no_tick_hold: assert property (!tb_tick_in |=> $stable(pwm_output_a_out)
		&& $stable(pwm_output_b_out)) else $error("output moved without tick");
	a_zero_action: assert property (tb_tick_in && ctr_zero_in && okb
		|=> pwm_output_b_out == nx(act_q[1:0], $past(pwm_output_b_out))) else $error("zero action");
	a_period_action: assert property (tb_tick_in && ctr_period_in && !ctr_zero_in && okb
		|=> pwm_output_b_out == nx(act_q[3:2], $past(pwm_output_b_out))) else $error("period");
	a_compare_a_value_up: assert property (tb_tick_in && ctr_cmp_a_in && !ctr_zero_in && !ctr_period_in
		&& count_direction_in && okb |=> pwm_output_b_out == nx(act_q[5:4],
		$past(pwm_output_b_out))) else $error("compare A up action");
	a_compare_a_value_down: assert property (tb_tick_in && ctr_cmp_a_in && !ctr_zero_in && !ctr_period_in
		&& !ctr_cmp_b_in && !count_direction_in && okb |=> $stable(pwm_output_b_out))
		else $error("compare A down moved B");
	a_compare_b_value_action: assert property (tb_tick_in && ctr_cmp_b_in && !ctr_cmp_a_in && !ctr_zero_in
		&& !ctr_period_in && okb |=> pwm_output_b_out == nx(count_direction_in ? act_q[9:8]
		: act_q[11:10], $past(pwm_output_b_out))) else $error("compare B action");
	a_oneshot_b: assert property (tb_tick_in && os_b_q && !cf_q
		|=> pwm_output_b_out == nx(osb_q, $past(pwm_output_b_out))) else $error("one-shot B");
	a_oneshot_a: assert property (tb_tick_in && os_a_q && !cf_q
		|=> pwm_output_a_out == nx(osa_q, $past(pwm_output_a_out))) else $error("one-shot A");
endmodule // aq_force_checker
bind pwm_action_qualifier_force aq_force_checker u_aq_force_checker (.clk_in, .nrst_in,
	.wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out,
	.wb_ack_out, .wb_err_out, .tb_tick_in, .up_down_mode_in, .count_direction_in,
	.ctr_zero_in, .ctr_period_in, .ctr_cmp_a_in, .ctr_cmp_b_in, .out_a_event_in,
	.pwm_output_a_out, .pwm_output_b_out);
`default_nettype wire

// File: tb/pwm_action_qualifier_force_tb.sv
/*
 * Self-checking bench for the action qualifier with software forces.
 * Assumes the time-base stand-in and the bound port checker are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aq_force_defs.vh"
module pwm_action_qualifier_force_tb;
	logic clk_in = 0, nrst_in = 0, wb_cyc_in = 0, wb_stb_in = 0, wb_we_in = 0, req = 0;
	logic up_down_mode_in = 0, count_direction_in = 0;
	logic [7:0]  wb_adr_in = 8'h00;
	logic [3:0]  wb_sel_in = 4'h0, ev = 4'h0;
	logic [31:0] wb_dat_in = 32'h0;
	logic [1:0]  acta = 2'h0;
	wire logic [31:0] wb_dat_out;
	wire logic [1:0]  out_a_event_in;
	wire logic wb_ack_out, wb_err_out, tb_tick_in, ctr_zero_in, ctr_period_in;
	wire logic ctr_cmp_a_in, ctr_cmp_b_in, pwm_output_a_out, pwm_output_b_out;
	int err_total = 0, cmp_count = 0;
	always #2 clk_in = ~clk_in;
	pwm_action_qualifier_force u_pwm_action_qualifier_force (.clk_in, .nrst_in, .wb_cyc_in,
		.wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
		.wb_err_out, .tb_tick_in, .up_down_mode_in, .count_direction_in, .ctr_zero_in,
		.ctr_period_in, .ctr_cmp_a_in, .ctr_cmp_b_in, .out_a_event_in, .pwm_output_a_out,
		.pwm_output_b_out);
	tb_time_base u_tb_time_base (.clk_in, .req_in(req), .ev_in(ev), .act_in(acta),
		.tick_out(tb_tick_in), .zero_out(ctr_zero_in), .prd_out(ctr_period_in),
		.compare_a_value_out(ctr_cmp_a_in), .compare_b_value_out(ctr_cmp_b_in), .act_out(out_a_event_in));
	task automatic conclude;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// One classic cycle, held until ack or err is sampled; waits are bounded
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		{wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in, wb_sel_in} <= {2'h3, w, a, d, 4'hF};
		do begin @(posedge clk_in); n++; end while (wb_ack_out !== 1'b1 && wb_err_out !== 1'b1 && n < 40);
		q = wb_dat_out;
		e = wb_err_out;
		if (n >= 40) chk("bus wait", 32'h1, 32'h0);
		{wb_cyc_in, wb_stb_in} <= 2'h0;
		@(posedge clk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		wb(1'b1, a, d, q, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		wb(1'b0, a, 32'h0, q, e);
		chk("err", xe, e);
		if (!xe) chk("read", x, q);
	endtask
	// One tick with events {compare_b_value, compare_a_value, period, zero}, then both outputs compared
	task automatic tk(input logic [3:0] e, input logic d, input logic [1:0] aa, input logic xa, xb);
		{req, ev, count_direction_in, acta} <= {1'b1, e, d, aa};
		@(posedge clk_in);
		req <= 1'b0;
		repeat (2) @(posedge clk_in);
		chk("out_a", xa, pwm_output_a_out);
		chk("out_b", xb, pwm_output_b_out);
	endtask
	task automatic s_regs;
		rdc(`OFS_OUT_B_ACTION, 32'h0, 1'b0);
		rdc(`OFS_CONT_FORCE, 32'h0, 1'b0);
		wr(`OFS_OUT_B_ACTION, 32'hFFFF);
		rdc(`OFS_OUT_B_ACTION, 32'h0F3F, 1'b0);
		wr(`OFS_ONE_SHOT, 32'hFFFF);
		rdc(`OFS_ONE_SHOT, 32'h00DB, 1'b0);
		tk(4'h0, 1'b0, 2'h0, 1'b1, 1'b1);
		tk(4'h0, 1'b1, 2'h0, 1'b1, 1'b1);
		rdc(8'h40, 32'h0, 1'b1);
	endtask
	task automatic s_events;
		wr(`OFS_ONE_SHOT, 32'h0);
		wr(`OFS_OUT_B_ACTION, 32'h0939);
		tk(4'h1, 1'b0, 2'h0, 1'b1, 1'b0);
		tk(4'h2, 1'b1, 2'h0, 1'b1, 1'b1);
		tk(4'h4, 1'b1, 2'h0, 1'b1, 1'b0);
		tk(4'h4, 1'b0, 2'h0, 1'b1, 1'b0);
		tk(4'h8, 1'b0, 2'h0, 1'b1, 1'b1);
		tk(4'h8, 1'b1, 2'h0, 1'b1, 1'b0);
		tk(4'h3, 1'b1, 2'h0, 1'b1, 1'b0);
		tk(4'h0, 1'b0, 2'h1, 1'b0, 1'b0);
		wr(`OFS_ONE_SHOT, 32'h0030);
		tk(4'h0, 1'b0, 2'h0, 1'b0, 1'b1);
		tk(4'h1, 1'b0, 2'h0, 1'b0, 1'b0);
		wr(`OFS_ONE_SHOT, 32'h0006);
		tk(4'h0, 1'b1, 2'h1, 1'b1, 1'b0);
	endtask
	task automatic s_force;
		wr(`OFS_ONE_SHOT, 32'h00C0);
		wr(`OFS_CONT_FORCE, 32'h0009);
		rdc(`OFS_CONT_ACTIVE, 32'h9, 1'b0);
		tk(4'h1, 1'b0, 2'h2, 1'b0, 1'b1);
		wr(`OFS_CONT_FORCE, 32'h000F);
		tk(4'h1, 1'b0, 2'h2, 1'b1, 1'b0);
		wr(`OFS_ONE_SHOT, 32'h0);
		wr(`OFS_CONT_FORCE, 32'h0008);
		tk(4'h0, 1'b0, 2'h0, 1'b1, 1'b0);
		rdc(`OFS_CONT_ACTIVE, 32'hF, 1'b0);
		tk(4'h1, 1'b0, 2'h0, 1'b1, 1'b0);
		rdc(`OFS_CONT_ACTIVE, 32'h8, 1'b0);
		tk(4'h0, 1'b0, 2'h0, 1'b1, 1'b1);
	endtask
	// Reset for 8 cycles, three edges of settling, then the scenarios
	initial begin
		repeat (8) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		s_regs;
		s_events;
		s_force;
		conclude;
	end
	// Scenarios need well under a thousand cycles; a hang ends here
	initial begin
		#20000;
		err_total++;
		conclude;
	end
endmodule // pwm_action_qualifier_force_tb
`default_nettype wire

// File: tb/tb_time_base.sv
/*
 * Stand-in for the time-base and compare logic: one request becomes one tick.
 * Assumes requests are raised just after a rising edge for one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_time_base (
	input  wire logic       clk_in, req_in,
	input  wire logic [3:0] ev_in,
	input  wire logic [1:0] act_in,
	output var logic        tick_out, zero_out, prd_out, compare_a_value_out, compare_b_value_out,
	output var logic [1:0]  act_out
);
	initial {tick_out, zero_out, prd_out, compare_a_value_out, compare_b_value_out, act_out} = '0;
	// Between ticks the event lines flip, so stale levels must be ignored
	always @(posedge clk_in) begin
		tick_out <= req_in;
		if (req_in) {compare_b_value_out, compare_a_value_out, prd_out, zero_out, act_out} <= {ev_in, act_in};
		else {compare_b_value_out, compare_a_value_out, prd_out, zero_out, act_out} <=
			~{compare_b_value_out, compare_a_value_out, prd_out, zero_out, act_out};
	end
endmodule // tb_time_base
`default_nettype wire

// File: verilog/aq_action_apply.v
/*
 * Applies one two-bit action code to a current output level.
 * Pure combinational; assumes the caller registers the result.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aq_force_defs.vh"

module aq_action_apply (
	input  wire [1:0] action_in,
	input  wire       level_in,
	output reg        level_out,
	output reg        changes_out
);

	// Decode nothing, low, high or toggle
	always @* begin
		case (action_in)
			`ACT_LOW:    level_out = 1'b0;
			`ACT_HIGH:   level_out = 1'b1;
			`ACT_TOGGLE: level_out = ~level_in;
			default:     level_out = level_in;
		endcase
		changes_out = (action_in != `ACT_NONE);
	end

endmodule // aq_action_apply
`default_nettype wire

// File: verilog/aq_force_defs.vh
/*
 * Register map, field positions and reset values of the action-qualifier
 * force block. Assumes a 32-bit classic Wishbone slave with byte addressing.
 */
`ifndef AQ_FORCE_DEFS_VH
`define AQ_FORCE_DEFS_VH

// Register byte offsets
`define OFS_OUT_B_ACTION   8'h00
`define OFS_ONE_SHOT       8'h04
`define OFS_CONT_FORCE     8'h08
`define OFS_CONT_ACTIVE    8'h0C
`define OFS_STATUS         8'h10

// Action encodings
`define ACT_NONE           2'h0
`define ACT_LOW            2'h1
`define ACT_HIGH           2'h2
`define ACT_TOGGLE         2'h3

// Output B event action fields
`define FLD_ZERO_LSB       0
`define FLD_PERIOD_LSB     2
`define FLD_COMPARE_A_VALUE_UP_LSB    4
`define FLD_COMPARE_B_VALUE_UP_LSB    8
`define FLD_COMPARE_B_VALUE_DN_LSB    10
`define OUT_B_ACTION_MASK  16'h0F3F

// One-shot force fields
`define FLD_OS_ACT_A_LSB   0
`define FLD_OS_TRIG_A      2
`define FLD_OS_ACT_B_LSB   3
`define FLD_OS_TRIG_B      5
`define FLD_RELOAD_LSB     6
`define ONE_SHOT_RD_MASK   16'h00DB

// Continuous force fields
`define FLD_CF_A_LSB       0
`define FLD_CF_B_LSB       2
`define CONT_FORCE_MASK    16'h000F

// Reload selector values
`define RLD_ZERO           2'h0
`define RLD_PERIOD         2'h1
`define RLD_BOTH           2'h2
`define RLD_IMMEDIATE      2'h3

// Reset values
`define RST_OUT_B_ACTION   16'h0000
`define RST_ONE_SHOT       16'h0000
`define RST_CONT_FORCE     16'h0000

`endif

// File: verilog/pwm_action_qualifier_force.v
/*
 * Action qualifier with software forces for one PWM channel: counter-event
 * actions on output B, one-shot forces on A and B, continuous forces with
 * shadowed or immediate reload, and a Wishbone register slave.
 * Assumes event inputs come from the time-base and compare logic on the same
 * clock, each a one-cycle pulse per time-base tick; direction is a level.
 * Output A counter-event actions live elsewhere and arrive on out_a_event_in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aq_force_defs.vh"

module pwm_action_qualifier_force (
	input  wire        clk_in,
	input  wire        nrst_in,
	// Classic Wishbone slave
	input  wire        wb_cyc_in,
	input  wire        wb_stb_in,
	input  wire        wb_we_in,
	input  wire [7:0]  wb_adr_in,
	input  wire [3:0]  wb_sel_in,
	input  wire [31:0] wb_dat_in,
	output reg  [31:0] wb_dat_out,
	output reg         wb_ack_out,
	output reg         wb_err_out,
	// Time-base and compare events
	input  wire        tb_tick_in,
	input  wire        up_down_mode_in,
	input  wire        count_direction_in,
	input  wire        ctr_zero_in,
	input  wire        ctr_period_in,
	input  wire        ctr_cmp_a_in,
	input  wire        ctr_cmp_b_in,
	input  wire [1:0]  out_a_event_in,
	// Pre-dead-band outputs
	output reg         pwm_output_a_out,
	output reg         pwm_output_b_out
);

	reg         rst_s1_q;
	reg         rst_s2_q;
	wire        rst_n;
	reg  [15:0] output_b_action_control_q;
	reg  [1:0]  force_reload_select_q;
	reg  [1:0]  oneshot_action_out_a_q;
	reg  [1:0]  oneshot_action_out_b_q;
	reg         oneshot_trigger_out_a_q;
	reg         oneshot_trigger_out_b_q;
	reg  [3:0]  cont_shadow_q;
	reg  [3:0]  cont_active_q;
	wire        wb_req;
	wire        wr_strobe;
	reg         addr_ok;
	reg  [31:0] rd_data;
	wire        wr_one_shot;
	wire        wr_cont;
	wire        dir_eff;
	wire        evt_cmp_a_up;
	wire        evt_cmp_b_up;
	wire        evt_cmp_b_dn;
	reg  [1:0]  b_event_action;
	wire [1:0]  b_action;
	wire [1:0]  a_action;
	wire        shadow_load;
	wire [1:0]  cf_a;
	wire [1:0]  cf_b;
	wire        a_next;
	wire        b_next;
	wire        a_chg;
	wire        b_chg;

	// Reset release through two flops; assertion stays asynchronous
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	// Bus decode; ack is one cycle, dropped while it is high so it never doubles
	assign wb_req      = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out;
	assign wr_strobe   = wb_req & wb_we_in & addr_ok;
	assign wr_one_shot = wr_strobe & (wb_adr_in == `OFS_ONE_SHOT) & wb_sel_in[0];
	assign wr_cont     = wr_strobe & (wb_adr_in == `OFS_CONT_FORCE) & wb_sel_in[0];

	// Read mux; trigger bits are never stored as readable and read as zero
	always @* begin
		addr_ok = 1'b1;
		rd_data = 32'h00000000;
		case (wb_adr_in)
			`OFS_OUT_B_ACTION: rd_data[15:0] = output_b_action_control_q;
			`OFS_ONE_SHOT: begin
				rd_data[7:6] = force_reload_select_q;
				rd_data[4:3] = oneshot_action_out_b_q;
				rd_data[1:0] = oneshot_action_out_a_q;
			end
			`OFS_CONT_FORCE: rd_data[3:0] = (force_reload_select_q == `RLD_IMMEDIATE) ?
				cont_active_q : cont_shadow_q;
			`OFS_CONT_ACTIVE: rd_data[3:0] = cont_active_q;
			`OFS_STATUS: rd_data[1:0] = {pwm_output_b_out, pwm_output_a_out};
			default: addr_ok = 1'b0;
		endcase
	end

	// Bus answer one cycle after the request; unmapped addresses get err
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_out <= 1'b0;
			wb_err_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_ack_out <= wb_req & addr_ok;
			wb_err_out <= wb_req & ~addr_ok;
			if (wb_req & ~wb_we_in)
				wb_dat_out <= rd_data;
		end
	end

	// Configuration register writes, low byte lanes honoured by sel
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			output_b_action_control_q <= `RST_OUT_B_ACTION;
			force_reload_select_q     <= `RLD_ZERO;
			oneshot_action_out_a_q    <= `ACT_NONE;
			oneshot_action_out_b_q    <= `ACT_NONE;
		end else begin
			if (wr_strobe && wb_adr_in == `OFS_OUT_B_ACTION) begin
				if (wb_sel_in[0])
					output_b_action_control_q[7:0] <= wb_dat_in[7:0] & 8'h3F;
				if (wb_sel_in[1])
					output_b_action_control_q[15:8] <= wb_dat_in[15:8] & 8'h0F;
			end
			if (wr_one_shot) begin
				force_reload_select_q  <= wb_dat_in[`FLD_RELOAD_LSB+1:`FLD_RELOAD_LSB];
				oneshot_action_out_b_q <= wb_dat_in[`FLD_OS_ACT_B_LSB+1:`FLD_OS_ACT_B_LSB];
				oneshot_action_out_a_q <= wb_dat_in[`FLD_OS_ACT_A_LSB+1:`FLD_OS_ACT_A_LSB];
			end
		end
	end

	// One-shot triggers: set by writing 1, held until the next tick launches them
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			oneshot_trigger_out_a_q <= 1'b0;
			oneshot_trigger_out_b_q <= 1'b0;
		end else begin
			// Set wins over the launch clear so a trigger written on a tick is kept
			if (wr_one_shot && wb_dat_in[`FLD_OS_TRIG_B])
				oneshot_trigger_out_b_q <= 1'b1;
			else if (tb_tick_in)
				oneshot_trigger_out_b_q <= 1'b0;
			if (wr_one_shot && wb_dat_in[`FLD_OS_TRIG_A])
				oneshot_trigger_out_a_q <= 1'b1;
			else if (tb_tick_in)
				oneshot_trigger_out_a_q <= 1'b0;
		end
	end

	// Shadow load events; in immediate mode the bus writes the active copy
	assign shadow_load = tb_tick_in & (
		((force_reload_select_q == `RLD_ZERO)   & ctr_zero_in) |
		((force_reload_select_q == `RLD_PERIOD) & ctr_period_in) |
		((force_reload_select_q == `RLD_BOTH)   & (ctr_zero_in | ctr_period_in)));

	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			cont_shadow_q <= 4'h0;
			cont_active_q <= 4'h0;
		end else begin
			if (wr_cont)
				cont_shadow_q <= wb_dat_in[3:0];
			if (wr_cont && force_reload_select_q == `RLD_IMMEDIATE)
				cont_active_q <= wb_dat_in[3:0];
			else if (shadow_load)
				cont_active_q <= cont_shadow_q;
		end
	end

	// Effective direction: period means down and zero means up in up-down mode
	assign dir_eff = (up_down_mode_in & ctr_period_in) ? 1'b0 :
		(up_down_mode_in & ctr_zero_in) ? 1'b1 :
		count_direction_in;
	assign evt_cmp_a_up = ctr_cmp_a_in & dir_eff;
	assign evt_cmp_b_up = ctr_cmp_b_in & dir_eff;
	assign evt_cmp_b_dn = ctr_cmp_b_in & ~dir_eff;

	// One event per tick wins: zero, period, compare A up, then compare B
	always @* begin
		b_event_action = `ACT_NONE;
		if (ctr_zero_in)
			b_event_action = output_b_action_control_q[`FLD_ZERO_LSB+1:`FLD_ZERO_LSB];
		else if (ctr_period_in)
			b_event_action = output_b_action_control_q[`FLD_PERIOD_LSB+1:`FLD_PERIOD_LSB];
		else if (evt_cmp_a_up)
			b_event_action = output_b_action_control_q[`FLD_COMPARE_A_VALUE_UP_LSB+1:`FLD_COMPARE_A_VALUE_UP_LSB];
		else if (evt_cmp_b_up)
			b_event_action = output_b_action_control_q[`FLD_COMPARE_B_VALUE_UP_LSB+1:`FLD_COMPARE_B_VALUE_UP_LSB];
		else if (evt_cmp_b_dn)
			b_event_action = output_b_action_control_q[`FLD_COMPARE_B_VALUE_DN_LSB+1:`FLD_COMPARE_B_VALUE_DN_LSB];
	end

	// A pending one-shot stands in for the counter action, whatever the direction
	assign b_action = oneshot_trigger_out_b_q ? oneshot_action_out_b_q : b_event_action;
	assign a_action = oneshot_trigger_out_a_q ? oneshot_action_out_a_q : out_a_event_in;

	aq_action_apply u_apply_a (
		.action_in   (a_action),
		.level_in    (pwm_output_a_out),
		.level_out   (a_next),
		.changes_out (a_chg)
	);

	aq_action_apply u_apply_b (
		.action_in   (b_action),
		.level_in    (pwm_output_b_out),
		.level_out   (b_next),
		.changes_out (b_chg)
	);

	assign cf_a = cont_active_q[`FLD_CF_A_LSB+1:`FLD_CF_A_LSB];
	assign cf_b = cont_active_q[`FLD_CF_B_LSB+1:`FLD_CF_B_LSB];

	// Outputs update only on a tick, at most once each; continuous force on top
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pwm_output_a_out <= 1'b0;
			pwm_output_b_out <= 1'b0;
		end else if (tb_tick_in) begin
			if (cf_a == `ACT_LOW)
				pwm_output_a_out <= 1'b0;
			else if (cf_a == `ACT_HIGH)
				pwm_output_a_out <= 1'b1;
			else if (a_chg)
				pwm_output_a_out <= a_next;
			if (cf_b == `ACT_LOW)
				pwm_output_b_out <= 1'b0;
			else if (cf_b == `ACT_HIGH)
				pwm_output_b_out <= 1'b1;
			else if (b_chg)
				pwm_output_b_out <= b_next;
		end
	end

endmodule // pwm_action_qualifier_force
`default_nettype wire
